/* File: pcg_pkg.sv */
// constants for the peripheral clock gating block
package pcg_pkg;
  localparam int unsigned CLK_HZ = 50_000_000;
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned IDX_W = 12;
  // register indices; byte address is four times the index
  localparam logic [11:0] IDX_TIMER_GATE = 12'hF74;
  localparam logic [11:0] IDX_SERIAL_GATE = 12'hF75;
  localparam logic [11:0] IDX_SYNC_GATE = 12'hF76;
  localparam logic [11:0] IDX_EXTIRQ_GATE = 12'hF77;
  localparam logic [11:0] IDX_RESERVED_FIRST = 12'hE80;
  localparam logic [11:0] IDX_RESERVED_LAST = 12'hEFF;
  localparam logic [7:0] GATE_RESET = 8'h00;
  // timer_clock_gate fields
  localparam int unsigned TIMER_PAIR_B_BIT = 5;
  localparam int unsigned TIMER_PAIR_A_BIT = 4;
  localparam int unsigned CAPTURE_ONE_BIT = 1;
  localparam int unsigned CAPTURE_ZERO_BIT = 0;
  // serial_clock_gate fields
  localparam int unsigned TWO_WIRE_BIT = 4;
  localparam int unsigned ASYNC_TWO_BIT = 2;
  localparam int unsigned ASYNC_ONE_BIT = 1;
  localparam int unsigned ASYNC_ZERO_BIT = 0;
  // rtc_sync_serial_clock_gate fields
  localparam int unsigned CALENDAR_BIT = 2;
  localparam int unsigned SYNC_ONE_BIT = 1;
  localparam int unsigned SYNC_ZERO_BIT = 0;
  // ext_interrupt_clock_gate fields
  localparam int unsigned EXT_IRQ_LSB = 0;
  localparam int unsigned EXT_IRQ_COUNT = 6;
  localparam int unsigned GATE_COUNT = 17;
endpackage : pcg_pkg

/* File: pcg_clock_gating.sv */
// peripheral clock gating registers with apb slave and latch-based gates
//
// The APB slave port was left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - gate bit zero stops that peripheral clock
// - gate bit one supplies that peripheral clock
// - reset clears every gate bit
// - timer register: bits 5,4,1,0, all writable
// - serial register: bits 4,2,1,0, all writable
// - third register: calendar, sync serial gates
// - fourth register: external irq gates 5..0
module pcg_clock_gating (
  input wire logic SYS_CLK_I,
  input wire logic RST_I,
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [15:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  input wire logic [3:0] PSTRB_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  output wire logic [3:0] TIMER_CLK_O,
  output wire logic [3:0] SERIAL_CLK_O,
  output wire logic [2:0] SYNC_CLK_O,
  output wire logic [5:0] EXTIRQ_CLK_O
);

  logic [7:0] timer_gate;
  logic [7:0] serial_gate;
  logic [7:0] sync_gate;
  logic [7:0] extirq_gate;
  logic [pcg_pkg::GATE_COUNT-1:0] gate_en;
  logic [pcg_pkg::GATE_COUNT-1:0] gate_latch;
  logic [pcg_pkg::GATE_COUNT-1:0] gclk;
  logic access;
  logic complete;
  logic bad_addr;
  logic write_ok;
  logic [7:0] next_rdata;

  function automatic logic idx_hit(input logic [15:0] addr, input logic [11:0] idx);
    idx_hit = (addr[15:14] == 2'h0) && (addr[1:0] == 2'h0) && (addr[13:2] == idx);
  endfunction : idx_hit

  function automatic logic is_reserved(input logic [15:0] addr);
    logic [11:0] i;
    i = addr[13:2];
    is_reserved = (addr[15:14] != 2'h0) || (addr[1:0] != 2'h0) ||
                  ((i >= pcg_pkg::IDX_RESERVED_FIRST) && (i <= pcg_pkg::IDX_RESERVED_LAST));
  endfunction : is_reserved

  // error policy: reserved range, misaligned or high address bits;
  // such a transfer is answered with an error and never lands,
  // so a stray pointer cannot stop a running peripheral's clock
  assign access = PSEL_I && PENABLE_I;
  assign complete = access && PREADY_O;
  assign bad_addr = is_reserved(PADDR_I);
  assign write_ok = complete && PWRITE_I && PSTRB_I[0] && !bad_addr;

  // one wait state: ready rises in the second access cycle
  // the wait cycle gives read data a full cycle from the decode,
  // which keeps the address decode off the answer path
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PREADY_O <= 1'b0;
    end else begin
      PREADY_O <= access && !PREADY_O;
    end
  end

  always_comb begin
    next_rdata = 8'h00;
    if (idx_hit(PADDR_I, pcg_pkg::IDX_TIMER_GATE)) begin
      next_rdata = timer_gate;
    end else if (idx_hit(PADDR_I, pcg_pkg::IDX_SERIAL_GATE)) begin
      next_rdata = serial_gate;
    end else if (idx_hit(PADDR_I, pcg_pkg::IDX_SYNC_GATE)) begin
      next_rdata = sync_gate;
    end else if (idx_hit(PADDR_I, pcg_pkg::IDX_EXTIRQ_GATE)) begin
      next_rdata = extirq_gate;
    end
  end

  // read data and error are captured in the first access cycle
  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      PRDATA_O <= 32'h0000_0000;
      PSLVERR_O <= 1'b0;
    end else if (access && !PREADY_O) begin
      PRDATA_O <= (PWRITE_I || bad_addr) ? 32'h0000_0000 : {24'h00_0000, next_rdata};
      PSLVERR_O <= bad_addr;
    end else if (!access) begin
      PSLVERR_O <= 1'b0;
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      timer_gate <= pcg_pkg::GATE_RESET;
    end else if (write_ok && idx_hit(PADDR_I, pcg_pkg::IDX_TIMER_GATE)) begin
      timer_gate <= PWDATA_I[7:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      serial_gate <= pcg_pkg::GATE_RESET;
    end else if (write_ok && idx_hit(PADDR_I, pcg_pkg::IDX_SERIAL_GATE)) begin
      serial_gate <= PWDATA_I[7:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      sync_gate <= pcg_pkg::GATE_RESET;
    end else if (write_ok && idx_hit(PADDR_I, pcg_pkg::IDX_SYNC_GATE)) begin
      sync_gate <= PWDATA_I[7:0];
    end
  end

  always_ff @(posedge SYS_CLK_I or posedge RST_I) begin
    if (RST_I) begin
      extirq_gate <= pcg_pkg::GATE_RESET;
    end else if (write_ok && idx_hit(PADDR_I, pcg_pkg::IDX_EXTIRQ_GATE)) begin
      extirq_gate <= PWDATA_I[7:0];
    end
  end

  // flat enable vector, order matches the output groups
  assign gate_en = {
    extirq_gate[pcg_pkg::EXT_IRQ_LSB +: pcg_pkg::EXT_IRQ_COUNT],
    sync_gate[pcg_pkg::CALENDAR_BIT],
    sync_gate[pcg_pkg::SYNC_ONE_BIT],
    sync_gate[pcg_pkg::SYNC_ZERO_BIT],
    serial_gate[pcg_pkg::TWO_WIRE_BIT],
    serial_gate[pcg_pkg::ASYNC_TWO_BIT],
    serial_gate[pcg_pkg::ASYNC_ONE_BIT],
    serial_gate[pcg_pkg::ASYNC_ZERO_BIT],
    timer_gate[pcg_pkg::TIMER_PAIR_B_BIT],
    timer_gate[pcg_pkg::TIMER_PAIR_A_BIT],
    timer_gate[pcg_pkg::CAPTURE_ONE_BIT],
    timer_gate[pcg_pkg::CAPTURE_ZERO_BIT]
  };

  // latch is open only while the clock is low, so no runt pulse
  for (genvar g = 0; g < pcg_pkg::GATE_COUNT; g++) begin : g_gate
    always_latch begin
      if (!SYS_CLK_I) begin
        gate_latch[g] = gate_en[g];
      end
    end
    assign gclk[g] = SYS_CLK_I && gate_latch[g];
  end

  assign TIMER_CLK_O = gclk[3:0];
  assign SERIAL_CLK_O = gclk[7:4];
  assign SYNC_CLK_O = gclk[10:8];
  assign EXTIRQ_CLK_O = gclk[16:11];

  // software enables a gate before touching a peripheral and keeps it on
  // while the peripheral runs; a cleared gate simply stops the clock
  sequence s_access_wait;
    PSEL_I && PENABLE_I && !PREADY_O;
  endsequence

  sequence s_access_done;
    PSEL_I && PENABLE_I && PREADY_O;
  endsequence

  sequence s_read_wait(logic [11:0] idx);
    PSEL_I && PENABLE_I && !PREADY_O && !PWRITE_I && idx_hit(PADDR_I, idx);
  endsequence

  a_reset_gates_clear: assert property (@(posedge SYS_CLK_I)
    $fell(RST_I) |-> (timer_gate == 8'h00) && (serial_gate == 8'h00) && (sync_gate == 8'h00) &&
      (extirq_gate == 8'h00) && (gclk == '0))
    else $error("gate bits not cleared by reset");

  a_timer_write_lands: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (write_ok && idx_hit(PADDR_I, pcg_pkg::IDX_TIMER_GATE)) |=> (timer_gate == $past(PWDATA_I[7:0])))
    else $error("timer gate write lost");

  a_serial_write_lands: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (write_ok && idx_hit(PADDR_I, pcg_pkg::IDX_SERIAL_GATE)) |=> (serial_gate == $past(PWDATA_I[7:0])))
    else $error("serial gate write lost");

  a_sync_write_lands: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (write_ok && idx_hit(PADDR_I, pcg_pkg::IDX_SYNC_GATE)) |=> (sync_gate == $past(PWDATA_I[7:0])))
    else $error("sync gate write lost");

  a_extirq_write_lands: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (write_ok && idx_hit(PADDR_I, pcg_pkg::IDX_EXTIRQ_GATE)) |=> (extirq_gate == $past(PWDATA_I[7:0])))
    else $error("ext irq gate write lost");

  a_gate_stops_clock: assert property (@(negedge SYS_CLK_I) disable iff (RST_I)
    (gclk & ~$past(gate_en)) == '0)
    else $error("clock runs with gate bit zero");

  a_gate_runs_clock: assert property (@(negedge SYS_CLK_I) disable iff (RST_I)
    ($past(gate_en) & ~gclk) == '0)
    else $error("clock missing with gate bit one");

  a_no_high_at_rise: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    gclk == '0)
    else $error("gated clock high before rising edge");

  a_apb_one_wait: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    s_access_wait |=> PREADY_O ##1 !PREADY_O)
    else $error("apb answer not after one wait state");

  a_apb_reg_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !(PSEL_I && PENABLE_I && PREADY_O && PWRITE_I) |=> $stable(timer_gate))
    else $error("timer gate changed without a write");

  a_serial_reg_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !(PSEL_I && PENABLE_I && PREADY_O && PWRITE_I) |=> $stable(serial_gate))
    else $error("serial gate changed without a write");

  a_sync_reg_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !(PSEL_I && PENABLE_I && PREADY_O && PWRITE_I) |=> $stable(sync_gate))
    else $error("sync gate changed without a write");

  a_extirq_reg_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !(PSEL_I && PENABLE_I && PREADY_O && PWRITE_I) |=> $stable(extirq_gate))
    else $error("ext irq gate changed without a write");

  a_strobe_off_hold: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (complete && PWRITE_I && !PSTRB_I[0]) |=> $stable(timer_gate) && $stable(serial_gate) &&
      $stable(sync_gate) && $stable(extirq_gate))
    else $error("write landed with low byte strobe off");

  a_reserved_no_write: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (complete && PWRITE_I && bad_addr) |=> $stable(timer_gate) && $stable(serial_gate) &&
      $stable(sync_gate) && $stable(extirq_gate))
    else $error("reserved write changed a gate");

  a_read_timer_data: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    s_read_wait(pcg_pkg::IDX_TIMER_GATE) |=> (PRDATA_O == {24'h00_0000, $past(timer_gate)}))
    else $error("timer gate read back wrong");

  a_read_serial_data: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    s_read_wait(pcg_pkg::IDX_SERIAL_GATE) |=> (PRDATA_O == {24'h00_0000, $past(serial_gate)}))
    else $error("serial gate read back wrong");

  a_read_sync_data: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    s_read_wait(pcg_pkg::IDX_SYNC_GATE) |=> (PRDATA_O == {24'h00_0000, $past(sync_gate)}))
    else $error("sync gate read back wrong");

  a_read_extirq_data: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    s_read_wait(pcg_pkg::IDX_EXTIRQ_GATE) |=> (PRDATA_O == {24'h00_0000, $past(extirq_gate)}))
    else $error("ext irq gate read back wrong");

  a_ready_idle_low: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !access |=> !PREADY_O)
    else $error("ready raised outside an access");

  a_ready_pulse_one: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    s_access_done |=> !PREADY_O)
    else $error("ready held longer than one cycle");

  a_slverr_idle_clear: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    !access |=> !PSLVERR_O)
    else $error("error flag left standing after access");

  a_slverr_only_bad: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (PSLVERR_O && PREADY_O) |-> $past(bad_addr))
    else $error("error flag on a legal address");

  a_unmapped_no_error: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (s_access_wait and !bad_addr) |=> !PSLVERR_O)
    else $error("error flag on a legal access");

  a_write_rdata_zero: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (s_access_wait and PWRITE_I) |=> (PRDATA_O == 32'h0000_0000))
    else $error("read data not zero after a write");

  a_rdata_upper_zero: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    PRDATA_O[31:8] == 24'h00_0000)
    else $error("read data upper bits not zero");

  a_reset_bus_idle: assert property (@(posedge SYS_CLK_I)
    $fell(RST_I) |-> !PREADY_O && !PSLVERR_O && (PRDATA_O == 32'h0000_0000))
    else $error("bus outputs not idle after reset");

  a_reset_clocks_low: assert property (@(negedge SYS_CLK_I)
    (RST_I && $past(RST_I)) |-> (gclk == '0))
    else $error("gated clock running in reset");

  a_latch_follows_en: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    gate_latch == gate_en)
    else $error("gate latch missed the enable");

  a_reserved_error: assert property (@(posedge SYS_CLK_I) disable iff (RST_I)
    (s_access_wait and is_reserved(PADDR_I)) |=> PSLVERR_O && (PRDATA_O == 32'h0000_0000))
    else $error("reserved access not flagged");

endmodule : pcg_clock_gating
`default_nettype wire

/* File: pcg_periph_model.sv */
// stand-in peripherals counting the gated clock pulses they receive
`timescale 1ns/100ps
`default_nettype none
module pcg_periph_model (
  input wire logic rst_i,
  input wire logic [16:0] gclk_i,
  output logic [15:0] cnt_o [17]
);
  for (genvar g = 0; g < 17; g++) begin : g_cnt
    // a peripheral advances only on pulses it actually gets
    always_ff @(posedge gclk_i[g] or posedge rst_i) begin
      if (rst_i) begin
        cnt_o[g] <= 16'h0000;
      end else begin
        cnt_o[g] <= cnt_o[g] + 16'h0001;
      end
    end
  end
endmodule : pcg_periph_model
`default_nettype wire

/* File: peripheral_clock_gating_tb_top.sv */
// testbench for the peripheral clock gating block
`timescale 1ns/100ps
`default_nettype none
module peripheral_clock_gating_tb_top;
  logic clk, rst, psel, pen, pwr, pready, pslverr;
  logic [15:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb, tclk, sclk;
  logic [2:0] yclk;
  logic [5:0] xclk;
  logic [15:0] cnt [17];
  logic [33:0] expq [$];
  logic [33:0] e;
  logic [7:0] g [4];
  logic [11:0] ix [4];
  int err_count = 0;
  int checked = 0;
  int i, r;
  integer seed = 32'h91d3a290;
  pcg_clock_gating u_dut (.SYS_CLK_I(clk), .RST_I(rst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr),
    .PADDR_I(paddr), .PWDATA_I(pwdata), .PSTRB_I(pstrb), .PRDATA_O(prdata), .PREADY_O(pready),
    .PSLVERR_O(pslverr), .TIMER_CLK_O(tclk), .SERIAL_CLK_O(sclk), .SYNC_CLK_O(yclk), .EXTIRQ_CLK_O(xclk));
  pcg_periph_model u_periph (.rst_i(rst), .gclk_i({xclk, yclk, sclk, tclk}), .cnt_o(cnt));
  always #10 clk = ~clk;
  task wrap_up;
    if (err_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask : wrap_up
  task check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      err_count++;
      $display("FAIL %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // expect word: {read, slverr, data}
  task apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd, input logic [3:0] st, input logic [33:0] ex);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pen <= 1'b0;
    pwr <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= wd;
    pstrb <= st;
    expq.push_back(ex);
    @(posedge clk);
    pen <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      err_count++;
      wrap_up();
    end
    psel <= 1'b0;
    pen <= 1'b0;
  endtask : apb
  function automatic logic [16:0] en_map(logic [7:0] r0, logic [7:0] r1, logic [7:0] r2, logic [7:0] r3);
    return {r3[5:0], r2[2:0], r1[4], r1[2:0], r0[5:4], r0[1:0]};
  endfunction : en_map
  // pulses in ten cycles per gated clock
  task clk_win(input logic [16:0] en);
    logic [15:0] c0 [17];
    @(negedge clk);
    c0 = cnt;
    repeat (10) @(negedge clk);
    for (int k = 0; k < 17; k++) begin
      check("gated clock pulses", 34'(cnt[k] - c0[k]), en[k] ? 34'h00000000A : 34'h000000000);
    end
  endtask : clk_win
  always @(posedge clk) begin
    if (psel && pen && pready === 1'b1) begin
      if (expq.size() == 0) begin
        check("unexpected answer", 34'h1, 34'h0);
      end else begin
        e = expq.pop_front();
        check("pslverr", 34'(pslverr), 34'(e[32]));
        if (e[33]) check("prdata", 34'(prdata), 34'(e[31:0]));
      end
    end
  end
  initial begin
    clk = 1'b0;
    rst = 1'b1;
    psel = 1'b0;
    pen = 1'b0;
    pwr = 1'b0;
    paddr = 16'h0000;
    pwdata = 32'h00000000;
    pstrb = 4'h0;
    ix = '{pcg_pkg::IDX_TIMER_GATE, pcg_pkg::IDX_SERIAL_GATE, pcg_pkg::IDX_SYNC_GATE, pcg_pkg::IDX_EXTIRQ_GATE};
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) apb(1'b0, ix[i], 32'h0, 4'h0, {2'b10, 32'h0});
    clk_win(17'h00000);
    for (r = 0; r < 4; r++) begin
      for (i = 0; i < 4; i++) begin
        g[i] = (r == 0) ? 8'hFF : 8'($random(seed));
        apb(1'b1, ix[i], {24'($random(seed)), g[i]}, 4'hF, 34'h0);
      end
      for (i = 0; i < 4; i++) apb(1'b0, ix[i], 32'h0, 4'h0, {2'b10, 24'h0, g[i]});
      clk_win(en_map(g[0], g[1], g[2], g[3]));
    end
    // low byte strobe off: write must not land
    apb(1'b1, ix[0], {24'h0, ~g[0]}, 4'hE, 34'h0);
    apb(1'b0, ix[0], 32'h0, 4'h0, {2'b10, 24'h0, g[0]});
    apb(1'b1, pcg_pkg::IDX_RESERVED_FIRST, 32'hFF, 4'hF, {2'b01, 32'h0});
    apb(1'b0, pcg_pkg::IDX_RESERVED_LAST, 32'h0, 4'h0, {2'b11, 32'h0});
    @(posedge clk);
    rst <= 1'b1;
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    for (i = 0; i < 4; i++) apb(1'b0, ix[i], 32'h0, 4'h0, {2'b10, 32'h0});
    clk_win(17'h00000);
    wrap_up();
  end
endmodule : peripheral_clock_gating_tb_top
`default_nettype wire
